// ===== design/demod_stream_ctrl.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module demod_stream_ctrl
  import demod_stream_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ext_trig,
  input wire logic [3:0] waveform_generator_trig,
  input wire logic [NUM_DEMODS*SAMPLE_W-1:0] demod_data,
  output logic [NUM_DEMODS-1:0] sample_valid,
  output logic [NUM_DEMODS*SAMPLE_W-1:0] sample_data,
  output logic [NUM_DEMODS*FILT_W-1:0] filter_cfg,
  output logic [NUM_DEMODS-1:0] sinc_enable
);

  typedef struct packed {
    logic [NUM_DEMODS-1:0] stream_en;
    logic filt_lock;
    logic rate_lock;
    logic [NUM_DEMODS-1:0][RATE_W-1:0] div;
    logic [NUM_DEMODS-1:0][FILT_W-1:0] filt;
    logic [NUM_DEMODS-1:0][7:0] trig;
    logic [NUM_DEMODS-1:0][15:0] cnt;
    logic [NUM_DEMODS-1:0] valid;
    logic [NUM_DEMODS-1:0][SAMPLE_W-1:0] data;
    logic [31:0] rdata;
    logic err;
  } ctrl_state_t;

  ctrl_state_t q, d;

  logic [5:0] trig_lvl;
  logic [5:0] trig_rise;
  logic [5:0] trig_fall;
  logic [NUM_DEMODS-1:0] tick;
  logic [NUM_DEMODS-1:0] fire;

  // external pins first, internal lines too: all pass two flip-flops
  trig_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .trig_in({waveform_generator_trig, ext_trig}),
    .trig_lvl(trig_lvl),
    .trig_rise(trig_rise),
    .trig_fall(trig_fall)
  );

  // APB decode
  logic wr_en;
  logic rd_en;
  logic glob_hit;
  logic dm_hit;
  logic [2:0] dm_idx;
  logic [4:0] dm_ofs;

  assign wr_en = psel & penable & pwrite;
  // reads are decoded in the setup cycle, see read data below
  assign rd_en = psel & ~penable & ~pwrite;
  assign glob_hit = (paddr == OFS_STREAM_EN) | (paddr == OFS_LOCKS) |
                    (paddr == OFS_STATUS);
  assign dm_idx = paddr[DEMOD_STRIDE_LG +: 3];
  assign dm_ofs = paddr[4:0];
  assign dm_hit = (paddr[11:8] == OFS_DEMOD_BASE[11:8]) &
                  ((dm_ofs == OFS_D_RATE) | (dm_ofs == OFS_D_FILT) |
                   (dm_ofs == OFS_D_TRIG) | (dm_ofs == OFS_D_CNT));

  // nearest supported divider, clamped at both ends of range
  function automatic logic [RATE_W-1:0] clamp_div(input logic [31:0] v);
    if (v < DIV_MIN)
      return DIV_MIN;
    else if (v > DIV_MAX)
      return DIV_MAX;
    else
      return v;
  endfunction

  // select and qualify trigger for one demodulator
  function automatic logic [2:0] pick(
    input logic [3:0] src,
    input logic [5:0] v
  );
    unique case (src)
      SRC_EXT_A: return {1'b1, v[0], 1'b0};
      SRC_EXT_B: return {1'b1, v[1], 1'b0};
      SRC_EXT_OR: return {1'b1, v[0] | v[1], 1'b0};
      SRC_WFG_1: return {1'b1, v[2], 1'b0};
      SRC_WFG_2: return {1'b1, v[3], 1'b0};
      SRC_WFG_3: return {1'b1, v[4], 1'b0};
      SRC_WFG_4: return {1'b1, v[5], 1'b0};
      default: return 3'b000;
    endcase
  endfunction

  // OR-ed source edges come from the OR-ed level, so a delayed copy of it
  logic or_prev_q;
  logic or_lvl;
  logic or_rise;
  logic or_fall;
  assign or_lvl = trig_lvl[0] | trig_lvl[1];
  assign or_rise = or_lvl & ~or_prev_q;
  assign or_fall = ~or_lvl & or_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      or_prev_q <= 1'b0;
    else
      or_prev_q <= or_lvl;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_DEMODS; g++)
    begin : gen_demod
      logic [2:0] lv;
      logic [2:0] rs;
      logic [2:0] fl;
      logic is_cont;
      logic lvl;
      logic re;
      logic fe;
      logic restart;

      assign lv = pick(q.trig[g][3:0], trig_lvl);
      assign rs = pick(q.trig[g][3:0], trig_rise);
      assign fl = pick(q.trig[g][3:0], trig_fall);
      assign is_cont = ~lv[2];
      assign lvl = lv[1];
      assign re = (q.trig[g][3:0] == SRC_EXT_OR) ? or_rise : rs[1];
      assign fe = (q.trig[g][3:0] == SRC_EXT_OR) ? or_fall : fl[1];
      // the rate timer restarts while streaming is disabled for this demodulator
      assign restart = ~q.stream_en[g];

      // own timer per demodulator; aux output timing is not here
      rate_gen u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .div(q.div[g]),
        .restart(restart),
        .tick(tick[g])
      );

      always_comb
      begin
        fire[g] = 1'b0;
        if (is_cont)
          fire[g] = tick[g];
        else
        begin
          case (q.trig[g][6:4])
            MODE_RISING: fire[g] = re;
            MODE_FALLING: fire[g] = fe;
            MODE_BOTH: fire[g] = re | fe;
            MODE_HIGH: fire[g] = tick[g] & lvl;
            MODE_LOW: fire[g] = tick[g] & ~lvl;
            default: fire[g] = 1'b0;
          endcase
        end
      end

      AST_EDGE_IGNORES_RATE: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q.stream_en[g] && !is_cont && q.trig[g][6:4] == MODE_RISING
         && !re) |=> !sample_valid[g])
        else $error("sample sent without rising edge");

      AST_RISE_SENDS: assert property (@(posedge pclk)
        disable iff (!presetn)
        (q.stream_en[g] && !is_cont && q.trig[g][6:4] == MODE_RISING
         && re) |=> sample_valid[g])
        else $error("rising edge gave no sample");

      AST_LOW_GATES: assert property (@(posedge pclk)
        disable iff (!presetn)
        (!is_cont && q.trig[g][6:4] == MODE_HIGH && !lvl) |=>
        !sample_valid[g])
        else $error("sample sent while trigger low in high mode");
    end
  endgenerate

  integer i;
  always_comb
  begin
    d = q;
    d.valid = '0;
    d.err = 1'b0;
    d.rdata = '0;
    for (i = 0; i < NUM_DEMODS; i++)
    begin
      if (q.stream_en[i] && fire[i])
      begin
        d.valid[i] = 1'b1;
        d.data[i] = demod_data[i*SAMPLE_W +: SAMPLE_W];
        d.cnt[i] = q.cnt[i] + 16'h0001;
      end
    end
    if (psel && !penable && !(glob_hit || dm_hit))
      d.err = 1'b1;
    if (wr_en && glob_hit)
    begin
      if (paddr == OFS_STREAM_EN)
        d.stream_en = pwdata[NUM_DEMODS-1:0];
      else if (paddr == OFS_LOCKS)
      begin
        d.filt_lock = pwdata[0];
        d.rate_lock = pwdata[1];
        // rising lock copies demod 1; falling lock touches nothing
        if (pwdata[0] && !q.filt_lock)
          for (i = 1; i < NUM_DEMODS; i++)
            d.filt[i] = q.filt[0];
        if (pwdata[1] && !q.rate_lock)
          for (i = 1; i < NUM_DEMODS; i++)
            d.div[i] = q.div[0];
      end
    end
    if (wr_en && dm_hit)
    begin
      for (i = 0; i < NUM_DEMODS; i++)
      begin
        if (dm_ofs == OFS_D_RATE &&
            (i == int'(dm_idx) || q.rate_lock))
          d.div[i] = clamp_div(pwdata);
        if (dm_ofs == OFS_D_FILT &&
            (i == int'(dm_idx) || q.filt_lock))
          d.filt[i] = pwdata[FILT_W-1:0];
      end
      if (dm_ofs == OFS_D_TRIG)
        d.trig[dm_idx] = pwdata[7:0];
    end
    if (rd_en)
    begin
      if (paddr == OFS_STREAM_EN)
        d.rdata = 32'(q.stream_en);
      else if (paddr == OFS_LOCKS)
        d.rdata = {30'h0000_0000, q.rate_lock, q.filt_lock};
      else if (paddr == OFS_STATUS)
        d.rdata = {18'h0_0000, trig_lvl, q.valid};
      else if (dm_hit)
      begin
        unique case (dm_ofs)
          OFS_D_RATE: d.rdata = q.div[dm_idx];
          OFS_D_FILT: d.rdata = 32'(q.filt[dm_idx]);
          OFS_D_TRIG: d.rdata = 32'(q.trig[dm_idx]);
          default: d.rdata = 32'(q.cnt[dm_idx]);
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      for (int k = 0; k < NUM_DEMODS; k++)
      begin
        q.div[k] <= DIV_RESET;
        q.filt[k] <= FILT_RESET;
      end
    end
    else
      q <= d;
  end

  // read data and error are registered in the setup cycle, so the access
  // phase needs no wait state; a value changing during access shows its
  // setup-cycle state
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.err;
  assign prdata = q.rdata;

  assign sample_valid = q.valid;
  assign sample_data = q.data;
  assign filter_cfg = q.filt;
  for (g = 0; g < NUM_DEMODS; g++)
  begin : gen_sinc
    assign sinc_enable[g] = q.filt[g][FLT_SINC_BIT];
  end

  AST_STREAM_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (q.stream_en == '0) |=> (sample_valid == '0))
    else $error("sample sent with streaming disabled");

  AST_RATE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    (q.div[0] >= DIV_MIN) && (q.div[0] <= DIV_MAX))
    else $error("divider outside supported range");

  sequence rate_lock_rise_s;
    wr_en && paddr == OFS_LOCKS && pwdata[1] && !q.rate_lock;
  endsequence

  sequence filt_lock_rise_s;
    wr_en && paddr == OFS_LOCKS && pwdata[0] && !q.filt_lock;
  endsequence

  AST_RATE_LOCK_COPY: assert property (@(posedge pclk)
    disable iff (!presetn)
    rate_lock_rise_s |=>
    (q.div[NUM_DEMODS-1] == q.div[0]))
    else $error("rate lock did not copy demodulator 1");

  AST_FILT_LOCK_COPY: assert property (@(posedge pclk)
    disable iff (!presetn)
    filt_lock_rise_s |=>
    (q.filt[1] == q.filt[0]))
    else $error("filter lock did not copy demodulator 1");

  AST_LOCKED_WRITE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (q.rate_lock && wr_en && dm_hit && dm_ofs == OFS_D_RATE) |=>
    (q.div[3] == q.div[5]))
    else $error("locked rate write not applied to all");

  AST_UNLOCK_KEEPS: assert property (@(posedge pclk)
    disable iff (!presetn)
    (wr_en && paddr == OFS_LOCKS && !pwdata[1] && q.rate_lock) |=>
    $stable(q.div))
    else $error("releasing lock changed settings");

endmodule
`default_nettype wire

// ===== design/rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rate_gen
  import demod_stream_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [RATE_W-1:0] div,
  input wire logic restart,
  output logic tick
);

  typedef struct packed {
    logic [RATE_W-1:0] cnt;
    logic tick;
  } rate_state_t;

  rate_state_t q, d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (restart)
      d.cnt = '0;
    else if (q.cnt + 32'h0000_0001 >= div)
    begin
      d.cnt = '0;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

endmodule
`default_nettype wire

// ===== design/trig_sync.sv
`timescale 1ns/1ps
`default_nettype none
module trig_sync
  import demod_stream_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] trig_in,
  output logic [5:0] trig_lvl,
  output logic [5:0] trig_rise,
  output logic [5:0] trig_fall
);

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
  } sync_state_t;

  sync_state_t q, d;

  always_comb
  begin
    d = q;
    d.s1 = trig_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign trig_lvl = q.s2;
  assign trig_rise = q.s2 & ~q.s3;
  assign trig_fall = ~q.s2 & q.s3;

  AST_RISE_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    trig_rise[0] |=> !trig_rise[0])
    else $error("rise pulse longer than one cycle");

endmodule
`default_nettype wire

// ===== include/demod_stream_pkg.sv
package demod_stream_pkg;

  localparam int NUM_DEMODS = 8;
  localparam int SAMPLE_W = 32;
  localparam int RATE_W = 32;
  localparam int FILT_W = 24;

  // clock 200 MHz, period 5 ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 1000 / CLK_PERIOD_NS * 1000000;
  // supported rate range: 0.42 Sa/s to 14 MSa/s, divider in clock cycles
  localparam int RATE_MAX_MSPS = 14;
  localparam int RATE_MIN_CSPS = 42;
  localparam logic [RATE_W-1:0] DIV_MIN =
    RATE_W'(CLK_HZ / (RATE_MAX_MSPS * 1000000));
  localparam logic [RATE_W-1:0] DIV_MAX =
    RATE_W'(64'(CLK_HZ) * 100 / RATE_MIN_CSPS);
  localparam logic [RATE_W-1:0] DIV_RESET = 32'h0000_00c8;

  // register map, byte offsets
  localparam logic [11:0] OFS_STREAM_EN = 12'h000;
  localparam logic [11:0] OFS_LOCKS = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_DEMOD_BASE = 12'h100;
  localparam int DEMOD_STRIDE_LG = 5;
  localparam logic [4:0] OFS_D_RATE = 5'h00;
  localparam logic [4:0] OFS_D_FILT = 5'h04;
  localparam logic [4:0] OFS_D_TRIG = 5'h08;
  localparam logic [4:0] OFS_D_CNT = 5'h0c;

  // filter word fields
  localparam int FLT_VAL_LSB = 0;
  localparam int FLT_VAL_W = 16;
  localparam int FLT_ORD_LSB = 16;
  localparam int FLT_UNIT_LSB = 20;
  localparam int FLT_SINC_BIT = 22;
  localparam logic [FILT_W-1:0] FILT_RESET = 24'h00_0001;

  // trigger word fields
  localparam int TRG_SRC_LSB = 0;
  localparam int TRG_MODE_LSB = 4;

  typedef enum logic [1:0] {
    UNIT_TIME_CONSTANT,
    UNIT_NOISE_POWER_BW,
    UNIT_CUTOFF_BW
  } filter_unit_t;

  typedef enum logic [3:0] {
    SRC_CONTINUOUS, SRC_EXT_A, SRC_EXT_B, SRC_EXT_OR,
    SRC_WFG_1, SRC_WFG_2, SRC_WFG_3, SRC_WFG_4
  } trig_src_t;

  typedef enum logic [2:0] {
    MODE_RISING, MODE_FALLING, MODE_BOTH, MODE_HIGH, MODE_LOW
  } trig_mode_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] src;
  } trig_cfg_t;

  typedef struct packed {
    logic sample;
    logic [2:0] demod;
  } strobe_t;

endpackage

// ===== test/demod_stream_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %h got %h", what, exp, got); \
    end \
  end
module demod_stream_ctrl_test
  import demod_stream_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, word, v1, v2;
  logic [1:0] ext_trig;
  logic [3:0] waveform_generator_trig;
  logic [NUM_DEMODS*SAMPLE_W-1:0] demod_data, sample_data;
  logic [NUM_DEMODS-1:0] sample_valid, sinc_enable;
  logic [NUM_DEMODS*FILT_W-1:0] filter_cfg;
  logic [4:0] ofs;
  int bad_count, checks, seed, snap, n, w, act;
  logic [31:0] rq [3] = '{32'h0000_0001, 32'h0000_03e8, 32'hffff_ffff};
  logic [31:0] rx [3] = '{DIV_MIN, 32'h0000_03e8, DIV_MAX};

  demod_stream_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig(ext_trig), .waveform_generator_trig(waveform_generator_trig),
    .demod_data(demod_data), .sample_valid(sample_valid),
    .sample_data(sample_data), .filter_cfg(filter_cfg),
    .sinc_enable(sinc_enable));
  host_sink host_u (.pclk(pclk), .presetn(presetn),
    .sample_valid(sample_valid), .sample_data(sample_data));

  always #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function logic [11:0] dreg(input int i, input logic [4:0] o);
    return OFS_DEMOD_BASE + 12'(i * 32) + 12'(o);
  endfunction

  function logic in_rng(input int v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction

  task set_trig(input int src, input logic v);
    @(posedge pclk);
    // the or source picks its pin by the parity of the random pulse count n, so either input can feed it
    if (src == 1 || (src == 3 && !n[0]))
      ext_trig[0] <= v;
    else if (src <= 3)
      ext_trig[1] <= v;
    else
      waveform_generator_trig[src-4] <= v;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #(40000 * CLK_PERIOD_NS);
    bad_count++;
    wrap_up;
  end

  initial
  begin
    seed = 63575;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ext_trig = '0;
    waveform_generator_trig = '0;
    for (int i = 0; i < NUM_DEMODS; i++)
      demod_data[i*SAMPLE_W +: SAMPLE_W] = $random(seed);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_STREAM_EN, 0);
    `CHK("stream_en reset", 32'h0000_0000, rd);
    for (int i = 0; i < NUM_DEMODS; i++)
    begin
      apb(0, dreg(i, OFS_D_RATE), 0);
      `CHK("rate reset", DIV_RESET, rd);
      apb(0, dreg(i, OFS_D_FILT), 0);
      `CHK("filter reset", 32'(FILT_RESET), rd);
    end
    apb(0, 12'h010, 0);
    `CHK("unmapped slverr", 1'b1, err);
    for (int k = 0; k < 3; k++)
    begin
      apb(1, dreg(k, OFS_D_RATE), rq[k]);
      apb(0, dreg(k, OFS_D_RATE), 0);
      `CHK("rate clamp", rx[k], rd);
    end
    // fastest rate keeps the run short; host guidance is not enforced
    apb(1, dreg(0, OFS_D_RATE), 32'(DIV_MIN));
    apb(1, dreg(0, OFS_D_TRIG), 0);
    apb(1, OFS_STREAM_EN, 1);
    set_trig(1, 1'b1);
    snap = host_u.got[0];
    repeat (10 * DIV_MIN) @(posedge pclk);
    `CHK("continuous", 1'b1, in_rng(host_u.got[0] - snap, 9, 11));
    `CHK("disabled stream", 0, host_u.got[1]);
    `CHK("sample data", demod_data[SAMPLE_W-1:0], host_u.last[0]);
    set_trig(1, 1'b0);
    for (int s = 1; s < 8; s++)
      for (int m = 0; m < 3; m++)
      begin
        apb(1, dreg(0, OFS_D_TRIG), 32'(m * 16 + s));
        repeat (4) @(posedge pclk);
        snap = host_u.got[0];
        n = 1 + ($unsigned($random(seed)) % 4);
        for (int k = 0; k < n; k++)
        begin
          w = 3 + ($unsigned($random(seed)) % 8);
          set_trig(s, 1'b1);
          repeat (w) @(posedge pclk);
          set_trig(s, 1'b0);
          repeat (w) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        act = host_u.got[0] - snap;
        n = n * ((m == MODE_BOTH) ? 2 : 1);
        `CHK("edge count", n, act);
      end
    for (int m = 3; m < 5; m++)
      for (int lv = 1; lv >= 0; lv--)
      begin
        apb(1, dreg(0, OFS_D_TRIG), 32'(m * 16 + 2 + m));
        set_trig(2 + m, lv[0]);
        repeat (4) @(posedge pclk);
        snap = host_u.got[0];
        repeat (10 * DIV_MIN) @(posedge pclk);
        act = ((m == MODE_HIGH) == (lv == 1)) ? 9 : 0;
        n = host_u.got[0] - snap;
        `CHK("level count", 1'b1, in_rng(n, act, act + act / 4));
      end
    set_trig(5, 1'b0);
    apb(1, OFS_STREAM_EN, 0);
    apb(0, dreg(0, OFS_D_CNT), 0);
    `CHK("sample count", 32'(16'(host_u.got[0])), rd);
    for (int k = 0; k < 3; k++)
    begin
      word = {8'h00, 1'b0, k[0], 2'(k), 4'h3, 16'($random(seed))};
      apb(1, dreg(k, OFS_D_FILT), word);
      apb(0, dreg(k, OFS_D_FILT), 0);
      `CHK("filter word", word, rd);
      v1 = 32'(filter_cfg[k*FILT_W +: FILT_W]);
      `CHK("filter port", word, v1);
      `CHK("sinc port", word[FLT_SINC_BIT], sinc_enable[k]);
    end
    for (int s = 0; s < 2; s++)
    begin
      ofs = s ? OFS_D_RATE : OFS_D_FILT;
      v1 = s ? 32'h0000_0064 : word;
      v2 = s ? 32'h0000_0032 : {8'h00, 8'h12, 16'($random(seed))};
      apb(1, dreg(0, ofs), v1);
      apb(1, OFS_LOCKS, 32'(s + 1));
      apb(0, OFS_LOCKS, 0);
      `CHK("lock bits", 32'(s + 1), rd);
      apb(0, dreg(6, ofs), 0);
      `CHK("lock copy", v1, rd);
      apb(1, dreg(3, ofs), v2);
      apb(0, dreg(0, ofs), 0);
      `CHK("locked write", v2, rd);
      apb(1, OFS_LOCKS, 0);
      apb(0, dreg(7, ofs), 0);
      `CHK("unlock keeps", v2, rd);
      apb(1, dreg(7, ofs), v1);
      apb(0, dreg(0, ofs), 0);
      `CHK("independent", v2, rd);
    end
    wrap_up;
  end
endmodule
`default_nettype wire

// ===== test/host_sink.sv
`timescale 1ns/1ps
`default_nettype none
module host_sink
  import demod_stream_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_DEMODS-1:0] sample_valid,
  input wire logic [NUM_DEMODS*SAMPLE_W-1:0] sample_data
);
  // host takes every strobe at once; it never stalls the stream
  int got [NUM_DEMODS];
  logic [SAMPLE_W-1:0] last [NUM_DEMODS];
  always @(posedge pclk or negedge presetn)
  begin
    foreach (got[i])
    begin
      if (!presetn)
      begin
        got[i] <= 0;
        last[i] <= '0;
      end
      else if (sample_valid[i])
      begin
        got[i] <= got[i] + 1;
        last[i] <= sample_data[i*SAMPLE_W +: SAMPLE_W];
      end
    end
  end
endmodule
`default_nettype wire
